/* File: hw/pdv_top.sv */
// pulse relay, dialer, voice playback/record and analog compare blocks
// Overview of operation
// - rising trigger gives an output pulse of duration T, less up to one 10 ms tick
// - reset high forces the pulse output low
// - duration accepts 0.01 to 99.99 in seconds, minutes or hours
// - pulse timing resolved to better than half a second
// - trigger edges during a running pulse are ignored
// - dialer input high dials, redials every 30 s, stops when low
// - numbers up to 25 digits; longer numbers are rejected
// - dialer input chosen from inputs, outputs, high, low, markers, tone digits
// - each tone digit received once past the password is a pulse usable by a set-reset latch
// - incoming call needs password before information code and control digits
// - after password, star zero switches relay 1 on, star nine off
// - spoken confirmation of a remote switch lasts 5 seconds
// - playback on-input sets output and plays the selected section
// - playback off-input clears output and stops the section
// - voice store has 98 sections; playback selects one
// - recorder on-input starts recording, off-input ends it
// - recorder section 99 clears every stored section
// - reused recorder advances section number each on/off cycle, holding at 98
// - compare operands constant 0.0 to 10.0 or analog; five relations
// - compare output high while the chosen relation holds
`timescale 1ns/100ps
`default_nettype none
`include "pdv_defs.svh"
module pdv_top (
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  // single pulse relay
  input wire logic PULSE_TRIGGER_IN,
  input wire logic PULSE_RESET_IN,
  input wire logic [13:0] PULSE_T_IN,
  input wire pdv_pkg::pdv_unit_t PULSE_UNIT_IN,
  output logic PULSE_Q_OUT,
  // terminals and markers
  input wire logic [11:0] INPUT_TERMINALS_IN,
  input wire logic [7:0] OUTPUT_TERMINALS_IN,
  input wire logic [126:0] MARKER_BITS_IN,
  // dialer
  input wire pdv_pkg::pdv_src_t DIAL_SRC_IN,
  input wire logic [6:0] DIAL_IDX_IN,
  input wire logic [4:0] DIAL_LEN_IN,
  input wire logic [99:0] DIAL_NUMBER_IN,
  output logic DIAL_START_OUT,
  output logic [99:0] DIAL_NUMBER_OUT,
  output logic [4:0] DIAL_LEN_OUT,
  output logic DIAL_REJECT_OUT,
  // tone digits from the phone module
  input wire logic TONE_VALID_IN,
  input wire logic [3:0] TONE_DIGIT_IN,
  input wire logic CALL_ACTIVE_IN,
  input wire logic [15:0] PASSWORD_IN,
  output logic [9:0] TONE_DIGIT_SIGNALS_OUT,
  output logic PROMPT_PASSWORD_OUT,
  output logic PROMPT_INFO_OUT,
  output logic RELAY1_OUT,
  output logic CONFIRM_ON_OUT,
  output logic CONFIRM_OFF_OUT,
  // voice playback
  input wire logic VOICE_PLAYBACK_ON_IN,
  input wire logic VOICE_PLAYBACK_OFF_IN,
  input wire logic [6:0] VOICE_PLAYBACK_SECTION_IN,
  output logic VOICE_PLAYBACK_Q_OUT,
  output logic [6:0] VOICE_PLAYBACK_SECTION_OUT,
  // voice recorder
  input wire logic REC_ON_IN,
  input wire logic REC_OFF_IN,
  input wire logic [6:0] REC_SECTION_IN,
  output logic REC_ACTIVE_OUT,
  output logic [6:0] REC_SECTION_OUT,
  output logic REC_CLEAR_ALL_OUT,
  // analog compare
  input wire logic [6:0] ANA_A_IN,
  input wire logic [6:0] ANA_B_IN,
  input wire pdv_pkg::pdv_op_t ANA_OP_IN,
  output logic ANA_Q_OUT
);
  typedef struct packed {
    logic [1:0] trg_s;
    logic [1:0] rst_s;
    logic [23:0] tick_cnt;
    logic dial_in_d;
    logic [15:0] redial_cnt;
    logic dial_start;
    logic dial_reject;
    logic [99:0] dial_num;
    logic [4:0] dial_len;
    logic [9:0] tone_sig;
    logic [4:0] call;
    logic [2:0] pw_cnt;
    logic [15:0] pw_buf;
    logic relay1;
    logic conf_on;
    logic conf_off;
    logic [15:0] conf_cnt;
    logic voice_playback_q;
    logic [6:0] voice_playback_sec;
    logic rec_active;
    logic rec_started;
    logic [6:0] rec_sec;
    logic rec_clear;
    logic ana_q;
  } pdv_top_state_t;

  pdv_top_state_t s, next_s;
  logic tick;
  logic dial_level;
  logic rel;

  // 10 ms timebase shared by all timed blocks
  assign tick = (s.tick_cnt == 24'(`PDV_TICK_CYC - 1));

  // dialer source select
  always_comb begin
    unique case (DIAL_SRC_IN)
      pdv_pkg::PDV_SRC_INPUT: dial_level = INPUT_TERMINALS_IN[DIAL_IDX_IN[3:0]];
      pdv_pkg::PDV_SRC_OUTPUT: dial_level = OUTPUT_TERMINALS_IN[DIAL_IDX_IN[2:0]];
      pdv_pkg::PDV_SRC_HIGH: dial_level = 1'b1;
      pdv_pkg::PDV_SRC_LOW: dial_level = 1'b0;
      pdv_pkg::PDV_SRC_MARKER: dial_level = MARKER_BITS_IN[DIAL_IDX_IN];
      pdv_pkg::PDV_SRC_TONE: dial_level = s.tone_sig[DIAL_IDX_IN[3:0]];
      default: dial_level = 1'b0;
    endcase
  end

  // compare relation; inputs scaled 0..100 as tenths of a volt
  always_comb begin
    unique case (ANA_OP_IN)
      pdv_pkg::PDV_OP_LE: rel = ANA_A_IN <= ANA_B_IN;
      pdv_pkg::PDV_OP_GE: rel = ANA_A_IN >= ANA_B_IN;
      pdv_pkg::PDV_OP_GT: rel = ANA_A_IN > ANA_B_IN;
      pdv_pkg::PDV_OP_LT: rel = ANA_A_IN < ANA_B_IN;
      pdv_pkg::PDV_OP_EQ: rel = ANA_A_IN == ANA_B_IN;
      default: rel = 1'b0;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.trg_s = {s.trg_s[0], PULSE_TRIGGER_IN};
    next_s.rst_s = {s.rst_s[0], PULSE_RESET_IN};
    next_s.tick_cnt = tick ? 24'h0 : s.tick_cnt + 24'h1;
    // dialer: edge dials at once, then every 30 s while high
    next_s.dial_in_d = dial_level;
    next_s.dial_start = 1'b0;
    next_s.dial_reject = 1'b0;
    if (!dial_level) begin
      next_s.redial_cnt = 16'h0;
    end else if (!s.dial_in_d || (tick && s.redial_cnt == 16'(`PDV_REDIAL_TICKS - 1))) begin
      next_s.redial_cnt = 16'h0;
      if (DIAL_LEN_IN > `PDV_MAX_DIGITS || DIAL_LEN_IN == 5'h0) begin
        next_s.dial_reject = 1'b1;
      end else begin
        next_s.dial_start = 1'b1;
        next_s.dial_num = DIAL_NUMBER_IN;
        next_s.dial_len = DIAL_LEN_IN;
      end
    end else if (tick) begin
      next_s.redial_cnt = s.redial_cnt + 16'h1;
    end
    // tone digit pulses, only once the caller is past the password
    next_s.tone_sig = 10'h0;
    if (TONE_VALID_IN && TONE_DIGIT_IN <= 4'h9 && s.call != pdv_pkg::PDV_CALL_IDLE &&
        s.call != pdv_pkg::PDV_CALL_PASS) begin
      next_s.tone_sig = 10'h1 << TONE_DIGIT_IN;
    end
    // confirmation timer
    if (tick && s.conf_cnt != 16'h0) begin
      next_s.conf_cnt = s.conf_cnt - 16'h1;
      if (s.conf_cnt == 16'h1) begin
        next_s.conf_on = 1'b0;
        next_s.conf_off = 1'b0;
      end
    end
    // incoming call sequence
    if (!CALL_ACTIVE_IN) begin
      next_s.call = pdv_pkg::PDV_CALL_IDLE;
      next_s.pw_cnt = 3'h0;
    end else begin
      unique case (s.call)
        pdv_pkg::PDV_CALL_IDLE: begin
          next_s.call = pdv_pkg::PDV_CALL_PASS;
          next_s.pw_cnt = 3'h0;
        end
        pdv_pkg::PDV_CALL_PASS: begin
          if (TONE_VALID_IN && TONE_DIGIT_IN != `PDV_KEY_STAR) begin
            next_s.pw_buf = {s.pw_buf[11:0], TONE_DIGIT_IN};
            next_s.pw_cnt = s.pw_cnt + 3'h1;
            if (s.pw_cnt == `PDV_PW_DIGITS - 3'h1) begin
              next_s.pw_cnt = 3'h0;
              if ({s.pw_buf[11:0], TONE_DIGIT_IN} == PASSWORD_IN) begin
                next_s.call = pdv_pkg::PDV_CALL_INFO;
              end
            end
          end
        end
        pdv_pkg::PDV_CALL_INFO: begin
          if (TONE_VALID_IN && TONE_DIGIT_IN == `PDV_KEY_STAR) begin
            next_s.call = pdv_pkg::PDV_CALL_STAR;
          end
        end
        pdv_pkg::PDV_CALL_STAR: begin
          if (TONE_VALID_IN) begin
            next_s.call = pdv_pkg::PDV_CALL_INFO;
            if (TONE_DIGIT_IN == 4'h0) begin
              next_s.relay1 = 1'b1;
              next_s.conf_on = 1'b1;
              next_s.conf_off = 1'b0;
              next_s.conf_cnt = 16'(`PDV_CONFIRM_TICKS);
            end else if (TONE_DIGIT_IN == 4'h9) begin
              next_s.relay1 = 1'b0;
              next_s.conf_on = 1'b0;
              next_s.conf_off = 1'b1;
              next_s.conf_cnt = 16'(`PDV_CONFIRM_TICKS);
            end
          end
        end
        default: next_s.call = pdv_pkg::PDV_CALL_IDLE;
      endcase
    end
    // playback: off wins over on
    if (VOICE_PLAYBACK_OFF_IN) begin
      next_s.voice_playback_q = 1'b0;
    end else if (VOICE_PLAYBACK_ON_IN && VOICE_PLAYBACK_SECTION_IN != 7'h0 && VOICE_PLAYBACK_SECTION_IN <= `PDV_SECTIONS) begin
      next_s.voice_playback_q = 1'b1;
      next_s.voice_playback_sec = VOICE_PLAYBACK_SECTION_IN;
    end
    // recorder; section order kept by the user, accumulates on reuse
    next_s.rec_clear = 1'b0;
    if (!s.rec_started && REC_SECTION_IN != s.rec_sec) begin
      next_s.rec_sec = REC_SECTION_IN;
    end
    if (s.rec_active && REC_OFF_IN) begin
      next_s.rec_active = 1'b0;
      if (s.rec_sec < `PDV_SECTIONS) begin
        next_s.rec_sec = s.rec_sec + 7'h1;
      end
    end else if (!s.rec_active && REC_ON_IN && !REC_OFF_IN) begin
      // section 99 read from the pin, so a clear still works after recording has begun
      if (REC_SECTION_IN == `PDV_CLEAR_ALL) begin
        next_s.rec_clear = 1'b1;
        next_s.rec_started = 1'b0;
      end else if (s.rec_sec != 7'h0 && s.rec_sec <= `PDV_SECTIONS) begin
        next_s.rec_active = 1'b1;
        next_s.rec_started = 1'b1;
      end
    end
    next_s.ana_q = (ANA_A_IN <= `PDV_ANA_MAX) && (ANA_B_IN <= `PDV_ANA_MAX) && rel;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      s <= '0;
      s.call <= pdv_pkg::PDV_CALL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // pulse relay on synchronised pins
  pdv_single_pulse u_pulse (
    .clk_in(SYS_CLK_IN),
    .arst_n_in(ARST_N_IN),
    .tick_in(tick),
    .trg_in(s.trg_s[1]),
    .rst_in(s.rst_s[1]),
    .t_in(PULSE_T_IN),
    .unit_in(PULSE_UNIT_IN),
    .q_out(PULSE_Q_OUT)
  );

  assign DIAL_START_OUT = s.dial_start;
  assign DIAL_NUMBER_OUT = s.dial_num;
  assign DIAL_LEN_OUT = s.dial_len;
  assign DIAL_REJECT_OUT = s.dial_reject;
  assign TONE_DIGIT_SIGNALS_OUT = s.tone_sig;
  assign PROMPT_PASSWORD_OUT = (s.call == pdv_pkg::PDV_CALL_PASS);
  assign PROMPT_INFO_OUT = (s.call == pdv_pkg::PDV_CALL_INFO) || (s.call == pdv_pkg::PDV_CALL_STAR);
  assign RELAY1_OUT = s.relay1;
  assign CONFIRM_ON_OUT = s.conf_on;
  assign CONFIRM_OFF_OUT = s.conf_off;
  assign VOICE_PLAYBACK_Q_OUT = s.voice_playback_q;
  assign VOICE_PLAYBACK_SECTION_OUT = s.voice_playback_sec;
  assign REC_ACTIVE_OUT = s.rec_active;
  assign REC_SECTION_OUT = s.rec_sec;
  assign REC_CLEAR_ALL_OUT = s.rec_clear;
  assign ANA_Q_OUT = s.ana_q;
endmodule
`default_nettype wire

/* File: pkg/pdv_defs.svh */
// timing, widths and code constants for the pulse/dialer/voice/compare blocks
`ifndef PDV_DEFS_SVH
`define PDV_DEFS_SVH
`define PDV_CLK_HZ 10000000
`define PDV_TICK_MS 10
`define PDV_TICK_CYC (`PDV_CLK_HZ / 1000 * `PDV_TICK_MS)
`define PDV_REDIAL_S 30
`define PDV_REDIAL_TICKS (`PDV_REDIAL_S * 1000 / `PDV_TICK_MS)
`define PDV_CONFIRM_S 5
`define PDV_CONFIRM_TICKS (`PDV_CONFIRM_S * 1000 / `PDV_TICK_MS)
`define PDV_T_MIN 14'h0001
`define PDV_T_MAX 14'h270f
`define PDV_MAX_DIGITS 5'h19
`define PDV_SECTIONS 7'h62
`define PDV_CLEAR_ALL 7'h63
`define PDV_ANA_MAX 7'h64
`define PDV_KEY_STAR 4'ha
`define PDV_PW_DIGITS 3'h4
`endif

/* File: pkg/pdv_pkg.sv */
// types shared by the pulse/dialer/voice/compare blocks
package pdv_pkg;
  typedef enum logic [1:0] {PDV_UNIT_SEC = 2'h0, PDV_UNIT_MIN = 2'h1, PDV_UNIT_HOUR = 2'h2} pdv_unit_t;
  typedef enum logic [2:0] {PDV_OP_LE = 3'h0, PDV_OP_GE = 3'h1, PDV_OP_GT = 3'h2, PDV_OP_LT = 3'h3,
                            PDV_OP_EQ = 3'h4} pdv_op_t;
  typedef enum logic [2:0] {PDV_SRC_INPUT = 3'h0, PDV_SRC_OUTPUT = 3'h1, PDV_SRC_HIGH = 3'h2,
                            PDV_SRC_LOW = 3'h3, PDV_SRC_MARKER = 3'h4, PDV_SRC_TONE = 3'h5} pdv_src_t;
  typedef enum logic [4:0] {PDV_CALL_IDLE = 5'h01, PDV_CALL_PASS = 5'h02, PDV_CALL_INFO = 5'h04,
                            PDV_CALL_STAR = 5'h08, PDV_CALL_CONF = 5'h10} pdv_call_t;
  typedef struct packed {
    logic q;
    logic trg_d;
    logic [31:0] sub;
    logic [13:0] ticks;
  } pdv_pulse_t;
endpackage

/* File: hw/pdv_single_pulse.sv */
// single-pulse timer relay with trigger edge, reset and unit scaling
`timescale 1ns/100ps
`default_nettype none
`include "pdv_defs.svh"
module pdv_single_pulse (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic tick_in,
  input wire logic trg_in,
  input wire logic rst_in,
  input wire logic [13:0] t_in,
  input wire pdv_pkg::pdv_unit_t unit_in,
  output logic q_out
);
  pdv_pkg::pdv_pulse_t s, next_s;
  logic [31:0] sub_lim;

  // 10 ms tick count per 0.01 of the unit of duration, by unit
  always_comb begin
    unique case (unit_in)
      pdv_pkg::PDV_UNIT_SEC: sub_lim = 32'h1;
      pdv_pkg::PDV_UNIT_MIN: sub_lim = 32'h3c;
      pdv_pkg::PDV_UNIT_HOUR: sub_lim = 32'he10;
      default: sub_lim = 32'h1;
    endcase
  end

  // 10 ms tick resolution, far finer than half a second
  always_comb begin
    next_s = s;
    next_s.trg_d = trg_in;
    if (rst_in) begin
      next_s.q = 1'b0;
      next_s.sub = 32'h0;
      next_s.ticks = 14'h0;
    end else if (!s.q) begin
      if (trg_in && !s.trg_d && t_in >= `PDV_T_MIN && t_in <= `PDV_T_MAX) begin
        next_s.q = 1'b1;
        next_s.ticks = t_in;
        next_s.sub = 32'h0;
      end
    end else if (tick_in) begin
      // edges while high are ignored here
      if (s.sub + 32'h1 >= sub_lim) begin
        next_s.sub = 32'h0;
        next_s.ticks = s.ticks - 14'h1;
        if (s.ticks == 14'h1) begin
          next_s.q = 1'b0;
        end
      end else begin
        next_s.sub = s.sub + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.q;
endmodule
`default_nettype wire

/* File: tb/pdv_checker.sv */
// assertions on the top-level pins of the pdv block
`timescale 1ns/100ps
`default_nettype none
module pdv_checker (
  input wire logic SYS_CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic PULSE_TRIGGER_IN,
  input wire logic PULSE_RESET_IN,
  input wire logic PULSE_Q_OUT,
  input wire logic DIAL_START_OUT,
  input wire logic [4:0] DIAL_LEN_OUT,
  input wire logic TONE_VALID_IN,
  input wire logic [3:0] TONE_DIGIT_IN,
  input wire logic [9:0] TONE_DIGIT_SIGNALS_OUT,
  input wire logic PROMPT_PASSWORD_OUT,
  input wire logic PROMPT_INFO_OUT,
  input wire logic RELAY1_OUT,
  input wire logic CONFIRM_ON_OUT,
  input wire logic CONFIRM_OFF_OUT,
  input wire logic VOICE_PLAYBACK_OFF_IN,
  input wire logic VOICE_PLAYBACK_Q_OUT,
  input wire logic [6:0] REC_SECTION_IN,
  input wire logic REC_CLEAR_ALL_OUT
);
  // single clock domain, so clock and reset are stated once
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // three edges of latency through the trigger synchroniser
  property p_pulse_start; $rose(PULSE_Q_OUT) |-> $past(PULSE_TRIGGER_IN, 3); endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse without trigger");
  property p_pulse_rst; PULSE_RESET_IN [*4] |-> !PULSE_Q_OUT; endproperty
  a_pulse_rst: assert property (p_pulse_rst) else $error("pulse high under reset");
  property p_dial_len; DIAL_START_OUT |-> DIAL_LEN_OUT != 5'h00 && DIAL_LEN_OUT <= 5'h19; endproperty
  a_dial_len: assert property (p_dial_len) else $error("dial with bad length");
  property p_tone; |TONE_DIGIT_SIGNALS_OUT |-> $past(TONE_VALID_IN)
    && TONE_DIGIT_SIGNALS_OUT == 10'h001 << $past(TONE_DIGIT_IN); endproperty
  a_tone: assert property (p_tone) else $error("tone pulse wrong");
  property p_prompt; $rose(PROMPT_INFO_OUT) |-> $past(PROMPT_PASSWORD_OUT); endproperty
  a_prompt: assert property (p_prompt) else $error("info prompt skipped password");
  property p_relay; $changed(RELAY1_OUT) |-> (RELAY1_OUT ? CONFIRM_ON_OUT : CONFIRM_OFF_OUT); endproperty
  a_relay: assert property (p_relay) else $error("relay change unconfirmed");
  property p_voice_playback_off; VOICE_PLAYBACK_OFF_IN |=> !VOICE_PLAYBACK_Q_OUT; endproperty
  a_voice_playback_off: assert property (p_voice_playback_off) else $error("playback not stopped");
  property p_rec_clr; REC_CLEAR_ALL_OUT |-> $past(REC_SECTION_IN) == 7'h63; endproperty
  a_rec_clr: assert property (p_rec_clr) else $error("clear without section 99");
  // main scenarios reached
  c_pulse: cover property ($rose(PULSE_Q_OUT));
  c_relay: cover property ($rose(RELAY1_OUT));
  c_clear: cover property (REC_CLEAR_ALL_OUT);
endmodule
bind pdv_top pdv_checker i_chk (.*);
`default_nettype wire

/* File: tb/pdv_phone.sv */
// behavioural phone module: line state and keyed tone digits
`timescale 1ns/100ps
`default_nettype none
module pdv_phone (
  input wire logic clk_in,
  output logic call_out,
  output logic valid_out,
  output logic [3:0] digit_out
);
  initial begin
    {call_out, valid_out, digit_out} = 6'h05;
  end
  // caller picks up or hangs up
  task automatic call(input logic on);
    @(posedge clk_in);
    #1 call_out = on;
  endtask
  // valid lasts one cycle; digit lines then show the inverse, never a stale digit
  task automatic key(input logic [3:0] d);
    @(posedge clk_in);
    #1 {valid_out, digit_out} = {1'b1, d};
    @(posedge clk_in);
    #1 {valid_out, digit_out} = {1'b0, ~d};
    repeat (4) @(posedge clk_in);
  endtask
  // four digits, most significant first
  task automatic password(input logic [15:0] pw);
    for (int i = 3; i >= 0; i--) key(pw[i*4 +: 4]);
  endtask
  // star, then the switch code
  task automatic command(input logic [3:0] c);
    key(4'ha);
    key(c);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the pdv block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic SYS_CLK_IN, ARST_N_IN, PULSE_TRIGGER_IN, PULSE_RESET_IN, PULSE_Q_OUT, VOICE_PLAYBACK_ON_IN, VOICE_PLAYBACK_OFF_IN;
  logic VOICE_PLAYBACK_Q_OUT, REC_ON_IN, REC_OFF_IN, REC_ACTIVE_OUT, REC_CLEAR_ALL_OUT, DIAL_START_OUT;
  logic DIAL_REJECT_OUT, TONE_VALID_IN, CALL_ACTIVE_IN, ANA_Q_OUT, PROMPT_PASSWORD_OUT;
  logic PROMPT_INFO_OUT, RELAY1_OUT, CONFIRM_ON_OUT, CONFIRM_OFF_OUT, seen_clr;
  logic [13:0] PULSE_T_IN;
  logic [11:0] INPUT_TERMINALS_IN;
  logic [7:0] OUTPUT_TERMINALS_IN;
  logic [126:0] MARKER_BITS_IN;
  logic [6:0] DIAL_IDX_IN, VOICE_PLAYBACK_SECTION_IN, VOICE_PLAYBACK_SECTION_OUT, REC_SECTION_IN, REC_SECTION_OUT;
  logic [6:0] ANA_A_IN, ANA_B_IN;
  logic [4:0] DIAL_LEN_IN, DIAL_LEN_OUT;
  logic [99:0] DIAL_NUMBER_IN, DIAL_NUMBER_OUT;
  logic [3:0] TONE_DIGIT_IN;
  logic [15:0] PASSWORD_IN;
  logic [9:0] TONE_DIGIT_SIGNALS_OUT, seen_tones;
  pdv_pkg::pdv_unit_t PULSE_UNIT_IN;
  pdv_pkg::pdv_src_t DIAL_SRC_IN;
  pdv_pkg::pdv_op_t ANA_OP_IN;
  int failures, n_checks;
  pdv_top i_dut (.*);
  pdv_phone i_phone (.clk_in(SYS_CLK_IN), .call_out(CALL_ACTIVE_IN), .valid_out(TONE_VALID_IN),
    .digit_out(TONE_DIGIT_IN));
  initial begin
    SYS_CLK_IN = 1'b0;
    forever #50 SYS_CLK_IN = ~SYS_CLK_IN;
  end
  // sticky record so a one-cycle pulse is never missed
  always @(posedge SYS_CLK_IN) begin
    if (!ARST_N_IN) begin
      seen_tones <= 10'h000;
      seen_clr <= 1'b0;
    end else begin
      seen_tones <= seen_tones | TONE_DIGIT_SIGNALS_OUT;
      seen_clr <= seen_clr | REC_CLEAR_ALL_OUT;
    end
  end
  // hang guard
  initial begin
    #8000000;
    failures++;
    summarize();
  end
  task automatic step(input int n);
    repeat (n) @(posedge SYS_CLK_IN);
    #1;
  endtask
  task automatic chk(input logic [99:0] got, input logic [99:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // longest duration in seconds, so the pulse outlives the run
  task automatic t_pulse();
    PULSE_TRIGGER_IN = 1'b1;
    step(4);
    chk(PULSE_Q_OUT, 1'b1);
    PULSE_TRIGGER_IN = 1'b0;
    step(4);
    PULSE_TRIGGER_IN = 1'b1;
    step(4);
    chk(PULSE_Q_OUT, 1'b1);
    PULSE_RESET_IN = 1'b1;
    step(4);
    chk(PULSE_Q_OUT, 1'b0);
    {PULSE_RESET_IN, PULSE_TRIGGER_IN} = 2'h0;
    step(4);
    PULSE_TRIGGER_IN = 1'b1;
    step(4);
    chk(PULSE_Q_OUT, 1'b1);
  endtask
  task automatic dial(input pdv_pkg::pdv_src_t s, input logic [4:0] n, input logic ok);
    logic hit;
    logic bad;
    hit = 1'b0;
    bad = 1'b0;
    DIAL_SRC_IN = s;
    DIAL_LEN_IN = n;
    for (int k = 0; k < 6; k++) begin
      step(1);
      hit = hit | (ok ? DIAL_START_OUT : DIAL_REJECT_OUT);
      bad = bad | (ok ? DIAL_REJECT_OUT : DIAL_START_OUT);
    end
    chk({hit, bad}, 2'h2);
    if (ok) chk(DIAL_NUMBER_OUT, DIAL_NUMBER_IN);
    if (ok) chk(DIAL_LEN_OUT, n);
    DIAL_SRC_IN = pdv_pkg::PDV_SRC_LOW;
    step(2);
  endtask
  task automatic t_dial();
    MARKER_BITS_IN[126] = 1'b1;
    DIAL_IDX_IN = 7'h7e;
    dial(pdv_pkg::PDV_SRC_HIGH, 5'h19, 1'b1);
    dial(pdv_pkg::PDV_SRC_MARKER, 5'h01, 1'b1);
    dial(pdv_pkg::PDV_SRC_HIGH, 5'h1a, 1'b0);
  endtask
  task automatic t_call();
    i_phone.call(1'b1);
    step(2);
    chk(PROMPT_PASSWORD_OUT, 1'b1);
    i_phone.password(PASSWORD_IN);
    step(1);
    chk(PROMPT_INFO_OUT, 1'b1);
    i_phone.key(4'h7);
    step(1);
    chk(seen_tones, 10'h080);
    i_phone.command(4'h0);
    step(1);
    chk({RELAY1_OUT, CONFIRM_ON_OUT}, 2'h3);
    i_phone.command(4'h9);
    step(1);
    chk({RELAY1_OUT, CONFIRM_OFF_OUT}, 2'h1);
    i_phone.call(1'b0);
  endtask
  // off wins over on; 98 is the top section
  task automatic t_voice_playback();
    {VOICE_PLAYBACK_SECTION_IN, VOICE_PLAYBACK_ON_IN} = {7'h62, 1'b1};
    step(2);
    chk({VOICE_PLAYBACK_Q_OUT, VOICE_PLAYBACK_SECTION_OUT}, {1'b1, 7'h62});
    VOICE_PLAYBACK_OFF_IN = 1'b1;
    step(2);
    chk(VOICE_PLAYBACK_Q_OUT, 1'b0);
    {VOICE_PLAYBACK_ON_IN, VOICE_PLAYBACK_OFF_IN} = 2'h0;
  endtask
  // clear first, then sections in ascending order
  task automatic t_rec();
    {REC_SECTION_IN, REC_ON_IN} = {7'h63, 1'b1};
    step(3);
    chk({seen_clr, REC_ACTIVE_OUT}, 2'h2);
    {REC_SECTION_IN, REC_ON_IN} = {7'h01, 1'b0};
    step(2);
    REC_ON_IN = 1'b1;
    step(2);
    chk({REC_ACTIVE_OUT, REC_SECTION_OUT}, {1'b1, 7'h01});
    {REC_ON_IN, REC_OFF_IN} = 2'h1;
    step(2);
    chk({REC_ACTIVE_OUT, REC_SECTION_OUT}, {1'b0, 7'h02});
    REC_OFF_IN = 1'b0;
    // clear must still work once recording has started
    {REC_SECTION_IN, REC_ON_IN} = {7'h63, 1'b1};
    step(2);
    chk({REC_CLEAR_ALL_OUT, REC_SECTION_OUT}, {1'b1, 7'h63});
    REC_ON_IN = 1'b0;
  endtask
  task automatic t_ana();
    int a;
    logic e;
    ANA_B_IN = 7'h32;
    for (int k = 0; k < 15; k++) begin
      a = 49 + k % 3;
      ANA_OP_IN = pdv_pkg::pdv_op_t'(k / 3);
      ANA_A_IN = 7'(a);
      step(2);
      e = k < 3 ? a <= 50 : k < 6 ? a >= 50 : k < 9 ? a > 50 : k < 12 ? a < 50 : a == 50;
      chk(ANA_Q_OUT, e);
    end
    ANA_A_IN = 7'h65;
    ANA_OP_IN = pdv_pkg::PDV_OP_GT;
    step(2);
    chk(ANA_Q_OUT, 1'b0);
  endtask
  initial begin
    ARST_N_IN = 1'b0;
    {PULSE_TRIGGER_IN, PULSE_RESET_IN, VOICE_PLAYBACK_ON_IN, VOICE_PLAYBACK_OFF_IN, REC_ON_IN, REC_OFF_IN} = 6'h00;
    {INPUT_TERMINALS_IN, OUTPUT_TERMINALS_IN, MARKER_BITS_IN, DIAL_IDX_IN, DIAL_LEN_IN} = '0;
    {VOICE_PLAYBACK_SECTION_IN, REC_SECTION_IN, ANA_A_IN, ANA_B_IN} = '0;
    DIAL_NUMBER_IN = 100'h1234567890123456789012345;
    {PASSWORD_IN, PULSE_T_IN} = {16'h1234, 14'h270f};
    PULSE_UNIT_IN = pdv_pkg::PDV_UNIT_SEC;
    DIAL_SRC_IN = pdv_pkg::PDV_SRC_LOW;
    ANA_OP_IN = pdv_pkg::PDV_OP_GT;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge SYS_CLK_IN);
    #1 ARST_N_IN = 1'b1;
    step(1);
    chk({PULSE_Q_OUT, VOICE_PLAYBACK_Q_OUT, RELAY1_OUT, PROMPT_PASSWORD_OUT}, 4'h0);
    t_pulse();
    t_dial();
    t_call();
    t_voice_playback();
    t_rec();
    t_ana();
    summarize();
  end
endmodule
`default_nettype wire
